// >>> lsi_regs.vh
// register map, field positions and timing constants of the link status indicator
// Functional notes
// - each link drives its own bi-colour indicator
// - solid orange uninit, red overcurrent, green idle
// - no camera gives slow pulsing red
// - discovery with power: fast green/orange alternate
// - discovery without power: fast orange flash
// - trigger wait gives slow orange pulse
// - data transfer gives fast green flash
// - test packets: slow green/orange alternate
// - alive indicator blinks while PCIe clock present
// - second indicator lit only in L0
// - third indicator lit at Gen2, dark Gen1
// - fourth indicator lit with all four lanes
`ifndef LSI_REGS_VH
`define LSI_REGS_VH
`define LSI_ADDR_STATUS    12'h000
`define LSI_ADDR_IRQ_STAT  12'h004
`define LSI_ADDR_IRQ_CLR   12'h008
`define LSI_ADDR_IRQ_EN    12'h00C
`define LSI_ADDR_CTRL      12'h010
`define LSI_CTRL_RESET     32'h00000000
`define LSI_CTRL_FORCE_OFF 0
`define LSI_CLK_HZ         10000000
`define LSI_SLOW_HALF_MS   500
`define LSI_FAST_HALF_MS   100
`define LSI_SLOW_HALF_CYC  ((`LSI_CLK_HZ / 1000) * `LSI_SLOW_HALF_MS)
`define LSI_FAST_HALF_CYC  ((`LSI_CLK_HZ / 1000) * `LSI_FAST_HALF_MS)
`define LSI_ALIVE_TIMEOUT  16
`define LSI_COL_OFF        2'h0
`define LSI_COL_GREEN      2'h1
`define LSI_COL_RED        2'h2
`define LSI_COL_ORANGE     2'h3
`endif

// >>> lsi_top.v
// link and board status indicator driver with an APB register slave
`timescale 1ns/1ps
`include "lsi_regs.vh"
module lsi_top #(
    parameter N_LINKS   = 4,
    parameter SLOW_HALF = `LSI_SLOW_HALF_CYC,
    parameter FAST_HALF = `LSI_FAST_HALF_CYC,
    parameter ALIVE_TO  = `LSI_ALIVE_TIMEOUT
) (
    // clock and reset
    input  wire                 CLK,
    input  wire                 SRST,
    // apb slave
    input  wire                 PSEL,
    input  wire                 PENABLE,
    input  wire                 PWRITE,
    input  wire [11:0]          PADDR,
    input  wire [31:0]          PWDATA,
    output wire                 PREADY,
    output reg  [31:0]          PRDATA,
    output wire                 PSLVERR,
    // per-link status conditions, same clock domain
    input  wire                 SYS_INIT_DONE,
    input  wire [N_LINKS-1:0]   LINK_OVERCURRENT,
    input  wire [N_LINKS-1:0]   LINK_TEST_TX,
    input  wire [N_LINKS-1:0]   LINK_DISCOVERY,
    input  wire [N_LINKS-1:0]   LINK_POWER_ON,
    input  wire [N_LINKS-1:0]   LINK_CAMERA,
    input  wire [N_LINKS-1:0]   LINK_DATA_ACTIVE,
    input  wire [N_LINKS-1:0]   LINK_TRIG_WAIT,
    // pcie status, asynchronous
    input  wire                 PCIE_REFCLK_TICK,
    input  wire                 PCIE_L0,
    input  wire                 PCIE_GEN2,
    input  wire                 PCIE_X4,
    // leds: per link green and red, orange is both
    output reg  [N_LINKS-1:0]   LED_LINK_GREEN,
    output reg  [N_LINKS-1:0]   LED_LINK_RED,
    output reg  [3:0]           LED_BOARD,
    // interrupt
    output wire                 IRQ
);
    localparam CW = 24;
    localparam NW = 4 * N_LINKS;
    localparam [CW-1:0] SLOW_T  = SLOW_HALF;
    localparam [CW-1:0] FAST_T  = FAST_HALF;
    localparam [7:0]    ALIVE_T = ALIVE_TO;
    // one-hot register selects
    localparam SEL_STATUS = 0;
    localparam SEL_STAT   = 1;
    localparam SEL_CLR    = 2;
    localparam SEL_EN     = 3;
    localparam SEL_CTRL   = 4;

    // terminal count of a half-period divider, shared by both rates
    function at_end;
        input [CW-1:0] cnt;
        input [CW-1:0] half;
        begin
            at_end = (cnt == half - {{(CW-1){1'b0}}, 1'b1});
        end
    endfunction

    // blink-pattern timebase
    reg  [CW-1:0]  slow_cnt_r;
    reg  [CW-1:0]  fast_cnt_r;
    reg            slow_ph_r;
    reg            fast_ph_r;
    reg            slow_pulse_r;
    reg  [2:0]     pulse_cnt_r;

    always @(posedge CLK) begin
        if (SRST) begin
            slow_cnt_r   <= {CW{1'b0}};
            fast_cnt_r   <= {CW{1'b0}};
            slow_ph_r    <= 1'b0;
            fast_ph_r    <= 1'b0;
            slow_pulse_r <= 1'b0;
            pulse_cnt_r  <= 3'h0;
        end else begin
            if (at_end(slow_cnt_r, SLOW_T)) begin
                slow_cnt_r  <= {CW{1'b0}};
                slow_ph_r   <= ~slow_ph_r;
                pulse_cnt_r <= pulse_cnt_r + 3'h1;
            end else begin
                slow_cnt_r <= slow_cnt_r + 1'b1;
            end
            if (at_end(fast_cnt_r, FAST_T)) begin
                fast_cnt_r <= {CW{1'b0}};
                fast_ph_r  <= ~fast_ph_r;
            end else begin
                fast_cnt_r <= fast_cnt_r + 1'b1;
            end
            // pulse: short lit slot, long dark, to tell it apart from a flash
            slow_pulse_r <= (pulse_cnt_r == 3'h0);
        end
    end

    // three-stage synchronisers for the pcie pins
    reg  [3:0] s1_r;
    reg  [3:0] s2_r;
    reg  [3:0] s3_r;
    reg  [3:0] pcie_r;
    always @(posedge CLK) begin
        if (SRST) begin
            s1_r   <= 4'h0;
            s2_r   <= 4'h0;
            s3_r   <= 4'h0;
            pcie_r <= 4'h0;
        end else begin
            s1_r <= {PCIE_X4, PCIE_GEN2, PCIE_L0, PCIE_REFCLK_TICK};
            s2_r <= s1_r;
            s3_r <= s2_r;
            pcie_r <= (s2_r & s3_r) | (pcie_r & (s2_r | s3_r));
        end
    end

    // filtered pcie levels, named for the indicator each one feeds
    wire refclk_tick_f = pcie_r[0];
    wire link_l0_f     = pcie_r[1];
    wire speed_gen2_f  = pcie_r[2];
    wire width_x4_f    = pcie_r[3];

    // refclk presence: a toggle must be seen within the timeout window
    reg  [7:0] alive_to_r;
    reg        tick_d_r;
    reg        clk_present_r;
    reg        alive_ph_r;
    always @(posedge CLK) begin
        if (SRST) begin
            alive_to_r    <= 8'h00;
            tick_d_r      <= 1'b0;
            clk_present_r <= 1'b0;
        end else begin
            tick_d_r <= refclk_tick_f;
            if (tick_d_r != refclk_tick_f) begin
                alive_to_r    <= 8'h00;
                clk_present_r <= 1'b1;
            end else if (alive_to_r == ALIVE_T) begin
                clk_present_r <= 1'b0;
            end else begin
                alive_to_r <= alive_to_r + 8'h01;
            end
        end
    end

    // alive blink runs off the slow divider so it shares the slow rate
    always @(posedge CLK) begin
        if (SRST)
            alive_ph_r <= 1'b0;
        else if (slow_cnt_r == {CW{1'b0}})
            alive_ph_r <= clk_present_r & ~alive_ph_r;
    end

    // per-link mode selection
    function [1:0] link_colour;
        input       oc, uninit, test, disc, pwr, cam, data, trig;
        input       sph, fph, spl;
        begin
            if (oc)
                link_colour = `LSI_COL_RED;
            else if (uninit)
                link_colour = `LSI_COL_ORANGE;
            else if (test)
                link_colour = sph ? `LSI_COL_GREEN : `LSI_COL_ORANGE;
            else if (disc && pwr)
                link_colour = fph ? `LSI_COL_GREEN : `LSI_COL_ORANGE;
            else if (disc)
                link_colour = fph ? `LSI_COL_ORANGE : `LSI_COL_OFF;
            else if (cam && data)
                link_colour = fph ? `LSI_COL_GREEN : `LSI_COL_OFF;
            else if (cam && trig)
                link_colour = spl ? `LSI_COL_ORANGE : `LSI_COL_OFF;
            else if (cam)
                link_colour = `LSI_COL_GREEN;
            else
                link_colour = spl ? `LSI_COL_RED : `LSI_COL_OFF;
        end
    endfunction

    reg  [31:0]          ctrl_r;
    reg  [NW-1:0]        irq_stat_r;
    reg  [NW-1:0]        irq_en_r;
    reg  [NW-1:0]        ev_lvl_r;
    reg  [2*N_LINKS-1:0] colour_nxt;
    wire [NW-1:0]        ev_lvl;
    wire [NW-1:0]        ev_rise;
    wire                 force_off = ctrl_r[`LSI_CTRL_FORCE_OFF];
    integer              i;
    integer              j;

    // events: overcurrent, camera arrive, camera leave, discovery start
    assign ev_lvl  = {LINK_DISCOVERY, ~LINK_CAMERA, LINK_CAMERA, LINK_OVERCURRENT};
    assign ev_rise = ev_lvl & ~ev_lvl_r;

    // colour of every link chosen here, registered below so the leds never glitch
    always @* begin
        colour_nxt = {(2*N_LINKS){1'b0}};
        for (j = 0; j < N_LINKS; j = j + 1) begin
            colour_nxt[2*j +: 2] = link_colour(LINK_OVERCURRENT[j], ~SYS_INIT_DONE,
                                               LINK_TEST_TX[j], LINK_DISCOVERY[j],
                                               LINK_POWER_ON[j], LINK_CAMERA[j],
                                               LINK_DATA_ACTIVE[j], LINK_TRIG_WAIT[j],
                                               slow_ph_r, fast_ph_r, slow_pulse_r);
        end
    end

    always @(posedge CLK) begin
        if (SRST) begin
            LED_LINK_GREEN <= {N_LINKS{1'b0}};
            LED_LINK_RED   <= {N_LINKS{1'b0}};
        end else begin
            for (i = 0; i < N_LINKS; i = i + 1) begin
                LED_LINK_GREEN[i] <= colour_nxt[2*i] & ~force_off;
                LED_LINK_RED[i]   <= colour_nxt[2*i+1] & ~force_off;
            end
        end
    end

    // board leds 1 to 3 follow the filtered pcie levels one cycle later, led 0 follows the alive blink
    always @(posedge CLK) begin
        if (SRST) begin
            LED_BOARD <= 4'h0;
        end else begin
            LED_BOARD[0] <= alive_ph_r & ~force_off;
            LED_BOARD[1] <= link_l0_f & ~force_off;
            LED_BOARD[2] <= speed_gen2_f & ~force_off;
            LED_BOARD[3] <= width_x4_f & ~force_off;
        end
    end

    // register decode shared by the write, read and error paths
    function [4:0] reg_select;
        input [11:0] a;
        begin
            case (a)
                `LSI_ADDR_STATUS:   reg_select = 5'h01;
                `LSI_ADDR_IRQ_STAT: reg_select = 5'h02;
                `LSI_ADDR_IRQ_CLR:  reg_select = 5'h04;
                `LSI_ADDR_IRQ_EN:   reg_select = 5'h08;
                `LSI_ADDR_CTRL:     reg_select = 5'h10;
                default:            reg_select = 5'h00;
            endcase
        end
    endfunction

    // apb slave, zero wait states
    wire [4:0]    sel          = reg_select(PADDR);
    wire          hit          = |sel;
    wire          wr_en        = PSEL & PENABLE & PWRITE;
    wire          rd_ph        = PSEL & ~PWRITE;
    wire [NW-1:0] irq_clr_mask = (wr_en & sel[SEL_CLR]) ? PWDATA[NW-1:0] : {NW{1'b0}};
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit;
    assign IRQ     = |(irq_stat_r & irq_en_r);

    // status word needs at least four links to fill its led fields
    wire [31:0] status_word = {16'h0000, width_x4_f, speed_gen2_f, link_l0_f, clk_present_r,
                               LED_BOARD, LED_LINK_RED[3:0], LED_LINK_GREEN[3:0]};
    wire [31:0] irq_stat_w  = {{(32-NW){1'b0}}, irq_stat_r};
    wire [31:0] irq_en_w    = {{(32-NW){1'b0}}, irq_en_r};
    reg  [31:0] rd_word;
    always @* begin
        rd_word = 32'h00000000;
        if (sel[SEL_STATUS])
            rd_word = status_word;
        else if (sel[SEL_STAT])
            rd_word = irq_stat_w;
        else if (sel[SEL_EN])
            rd_word = irq_en_w;
        else if (sel[SEL_CTRL])
            rd_word = ctrl_r;
    end

    always @(posedge CLK) begin
        if (SRST)
            ev_lvl_r <= {NW{1'b0}};
        else
            ev_lvl_r <= ev_lvl;
    end

    // set wins over a clear in the same cycle
    always @(posedge CLK) begin
        if (SRST)
            irq_stat_r <= {NW{1'b0}};
        else
            irq_stat_r <= (irq_stat_r & ~irq_clr_mask) | ev_rise;
    end

    always @(posedge CLK) begin
        if (SRST)
            irq_en_r <= {NW{1'b0}};
        else if (wr_en && sel[SEL_EN])
            irq_en_r <= PWDATA[NW-1:0];
    end

    always @(posedge CLK) begin
        if (SRST)
            ctrl_r <= `LSI_CTRL_RESET;
        else if (wr_en && sel[SEL_CTRL])
            ctrl_r <= {31'h00000000, PWDATA[0]};
    end

    // read data is captured in the setup cycle so it stands through the access
    always @(posedge CLK) begin
        if (SRST)
            PRDATA <= 32'h00000000;
        else if (rd_ph && !PENABLE)
            PRDATA <= rd_word;
    end
endmodule // lsi_top

// >>> lsi_checker.sv
// assertions on the indicator outputs of lsi_top
`timescale 1ns/1ps
module lsi_checker #(parameter N_LINKS = 4) (
    // clock, reset and status
    input logic CLK, SRST, SYS_INIT_DONE, PCIE_L0, PCIE_GEN2, PCIE_X4,
    input logic [N_LINKS-1:0] LINK_OVERCURRENT, LINK_TEST_TX, LINK_DISCOVERY, LINK_POWER_ON,
    input logic [N_LINKS-1:0] LINK_CAMERA, LINK_DATA_ACTIVE, LINK_TRIG_WAIT,
    // indicators
    input logic [N_LINKS-1:0] LED_LINK_GREEN, LED_LINK_RED,
    input logic [3:0]         LED_BOARD
);
    logic               rst_r;
    logic [N_LINKS-1:0] h1, hi, oc_r, un_r, t_r, dp_r, ob_r, a_r, c_r, n_r;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    function automatic bit on(input logic [N_LINKS-1:0] m, v);
        return (m & v) == m;
    endfunction
    // masks of links whose strongest condition is each state; data and trigger imply camera
    assign h1 = LINK_OVERCURRENT | {N_LINKS{!SYS_INIT_DONE}} | LINK_TEST_TX;
    assign hi = h1 | LINK_DISCOVERY;
    always @(posedge CLK) begin
        rst_r <= SRST;
        oc_r  <= LINK_OVERCURRENT;
        un_r  <= SYS_INIT_DONE ? '0 : ~LINK_OVERCURRENT;
        t_r   <= SYS_INIT_DONE ? LINK_TEST_TX & ~LINK_OVERCURRENT : '0;
        dp_r  <= LINK_DISCOVERY & ~h1 & LINK_POWER_ON;
        ob_r  <= LINK_DISCOVERY & ~h1 & ~LINK_POWER_ON | LINK_TRIG_WAIT & ~LINK_DATA_ACTIVE & ~hi;
        a_r   <= LINK_DATA_ACTIVE & ~hi;
        c_r   <= LINK_CAMERA & ~(hi | LINK_DATA_ACTIVE | LINK_TRIG_WAIT);
        n_r   <= ~(LINK_CAMERA | hi);
    end
    a_solid_red: assert property (!rst_r |-> on(oc_r, LED_LINK_RED & ~LED_LINK_GREEN))
        else $error("overcurrent link not solid red");
    a_solid_orange: assert property (!rst_r |-> on(un_r, LED_LINK_RED & LED_LINK_GREEN))
        else $error("uninitialised link not solid orange");
    a_solid_green: assert property (!rst_r |-> on(c_r, LED_LINK_GREEN & ~LED_LINK_RED))
        else $error("idle camera link not solid green");
    a_nocam_red: assert property (!rst_r |-> on(n_r, ~LED_LINK_GREEN))
        else $error("empty link shows green");
    a_disc_power: assert property (!rst_r |-> on(dp_r, LED_LINK_GREEN))
        else $error("powered discovery lost green");
    a_orange_only: assert property (!rst_r |-> on(ob_r, ~(LED_LINK_GREEN ^ LED_LINK_RED)))
        else $error("orange pattern shows one die only");
    a_data_green: assert property (!rst_r |-> on(a_r, ~LED_LINK_RED))
        else $error("data link shows red");
    a_test_green: assert property (!rst_r |-> on(t_r, LED_LINK_GREEN))
        else $error("test packet link lost green");
    a_l0_led: assert property ($stable(PCIE_L0)[*8] |-> LED_BOARD[1] == PCIE_L0)
        else $error("power state indicator wrong");
    a_speed_width: assert property ($stable({PCIE_GEN2, PCIE_X4})[*8] |->
        LED_BOARD[3:2] == {PCIE_X4, PCIE_GEN2})
        else $error("speed or width indicator wrong");
endmodule // lsi_checker
bind lsi_top lsi_checker #(.N_LINKS(N_LINKS)) lsi_checker_i (.*);

// >>> lsi_led_model.sv
// link indicator model: reads each bi-colour pair as a colour code
`timescale 1ns/1ps
module lsi_led_model #(parameter N_LINKS = 4) (
    // dies of each link indicator
    input  logic [N_LINKS-1:0]   green,
    input  logic [N_LINKS-1:0]   red,
    // colour seen per link, two bits each
    output logic [2*N_LINKS-1:0] colour
);
    // both dies lit together look orange
    always_comb for (int i = 0; i < N_LINKS; i++) colour[2*i +: 2] = {red[i], green[i]};
endmodule // lsi_led_model

// >>> tb_lsi_top.sv
// self-checking bench for lsi_top: apb traffic, random link status, blink rates
`timescale 1ns/1ps
`include "lsi_regs.vh"
module tb_lsi_top;
    localparam int SH = 8, FH = 2;
    logic        CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, tick_en;
    logic        SYS_INIT_DONE, PCIE_REFCLK_TICK, PCIE_L0, PCIE_GEN2, PCIE_X4;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rs, r;
    logic [3:0]  LINK_OVERCURRENT, LINK_TEST_TX, LINK_DISCOVERY, LINK_POWER_ON, LINK_CAMERA;
    logic [3:0]  LINK_DATA_ACTIVE, LINK_TRIG_WAIT, LED_LINK_GREEN, LED_LINK_RED, LED_BOARD;
    logic [7:0]  colour;
    logic [1:0]  tdiv;
    logic [32:0] exp_q[$];
    int          fail_count, n_compared, n;
    lsi_top #(.SLOW_HALF(SH), .FAST_HALF(FH)) lsi_top_i (.*);
    lsi_led_model lsi_led_model_i (.green(LED_LINK_GREEN), .red(LED_LINK_RED), .colour(colour));
    initial begin
        CLK = 0;
        forever #50 CLK = ~CLK;
    end
    // refclk stand-in toggles every fourth edge, slow enough to pass the pin filter
    always @(posedge CLK) begin
        tdiv <= tdiv + 2'h1;
        if (tick_en && tdiv == 2'h0) PCIE_REFCLK_TICK <= ~PCIE_REFCLK_TICK;
    end
    always @(posedge CLK) if (PSEL && PENABLE && PREADY && !PWRITE)
        chk("prdata", {PSLVERR, PRDATA}, exp_q.pop_front());
    function logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task chk(input string nm, input logic [32:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish();
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // entered just after a rising edge; request held until pready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int k;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, w, a, d};
        if (!w) exp_q.push_back(e);
        @(posedge CLK) PENABLE <= 1;
        k = 0;
        do begin @(posedge CLK); k++; end while (!PREADY && k < 20);
        {PSEL, PENABLE} <= 2'h0;
        if (!PREADY) begin fail_count++; tally_and_finish(); end
        @(posedge CLK);
    endtask
    task irq_is(input logic e);
        @(negedge CLK) chk("irq", IRQ, e);
        @(posedge CLK);
    endtask
    // transitions of one indicator over 64 cycles, after a short settle
    task cnt(input int w);
        logic p, v;
        n = 0;
        repeat (5) @(negedge CLK);
        p = w == 0 ? LED_LINK_GREEN[0] : w == 1 ? LED_LINK_RED[0] : LED_BOARD[0];
        repeat (64) begin
            @(negedge CLK);
            v = w == 0 ? LED_LINK_GREEN[0] : w == 1 ? LED_LINK_RED[0] : LED_BOARD[0];
            n += (v !== p);
            p = v;
        end
        @(posedge CLK);
    endtask
    initial begin
        rs = 32'h0000E28F;
        tdiv = 2'h0;
        {SRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {1'b1, 47'h0};
        {SYS_INIT_DONE, PCIE_REFCLK_TICK, PCIE_L0, PCIE_GEN2, PCIE_X4, tick_en} = 6'h0;
        {LINK_OVERCURRENT, LINK_TEST_TX, LINK_DISCOVERY, LINK_POWER_ON} = 16'h0;
        {LINK_CAMERA, LINK_DATA_ACTIVE, LINK_TRIG_WAIT} = 12'h0;
        {fail_count, n_compared} = 0;
        repeat (3) @(posedge CLK);
        SRST <= 0;
        apb(0, `LSI_ADDR_CTRL, 32'h0, 33'h0);
        apb(0, 12'h020, 32'h0, 33'h100000000);
        apb(1, `LSI_ADDR_IRQ_CLR, 32'hFFFFFFFF, 33'h0);
        apb(1, `LSI_ADDR_IRQ_EN, 32'h1, 33'h0);
        apb(0, `LSI_ADDR_IRQ_EN, 32'h0, 33'h1);
        LINK_OVERCURRENT <= 4'h1;
        repeat (4) @(posedge CLK);
        apb(0, `LSI_ADDR_IRQ_STAT, 32'h0, 33'h1);
        irq_is(1);
        apb(1, `LSI_ADDR_IRQ_EN, 32'h0, 33'h0);
        irq_is(0);
        apb(1, `LSI_ADDR_IRQ_CLR, 32'h1, 33'h0);
        apb(0, `LSI_ADDR_IRQ_STAT, 32'h0, 33'h0);
        apb(0, `LSI_ADDR_IRQ_CLR, 32'h0, 33'h0);
        repeat (40) begin
            r = xs();
            LINK_OVERCURRENT <= r[3:0] & r[7:4] & r[11:8];
            LINK_TEST_TX <= r[15:12] & r[19:16];
            LINK_DISCOVERY <= r[23:20] & r[27:24];
            LINK_POWER_ON <= r[31:28];
            r = xs();
            {LINK_CAMERA, LINK_DATA_ACTIVE, LINK_TRIG_WAIT} <= {r[3:0], r[3:0] & r[7:4], r[3:0] & r[11:8]};
            {PCIE_L0, PCIE_GEN2, PCIE_X4, tick_en, SYS_INIT_DONE} <= {r[15:12], |r[18:16]};
            repeat (24) @(posedge CLK);
        end
        {LINK_OVERCURRENT, LINK_TEST_TX, LINK_DISCOVERY, LINK_DATA_ACTIVE, LINK_TRIG_WAIT} <= 20'h0;
        {LINK_CAMERA, SYS_INIT_DONE, tick_en} <= 6'h3F;
        repeat (3) @(negedge CLK);
        chk("colour", colour, {4{`LSI_COL_GREEN}});
        @(posedge CLK) LINK_DATA_ACTIVE <= 4'hF;
        cnt(0);
        chk("fast", n >= 64 / FH - 1, 1);
        cnt(2);
        chk("alive", n >= 64 / SH - 1 && n <= 64 / SH + 1, 1);
        LINK_TEST_TX <= 4'hF;
        cnt(1);
        chk("slow", n >= 64 / SH - 1 && n <= 64 / SH + 1, 1);
        tick_en <= 0;
        repeat (40) @(posedge CLK);
        cnt(2);
        chk("alive stop", {n, LED_BOARD[0]}, 33'h0);
        tally_and_finish();
    end
endmodule // tb_lsi_top
